// ==== hdl/lcd_cursor_scan.sv ====
// Cursor register, host memory access and raster scan address logic
`timescale 1ns/1ps
module lcd_cursor_scan #(
	parameter int HIDE_CLKS = lcd_scan_pkg::CURSOR_HIDE_CLKS
) (
	input  wire logic                     clk,        // System clock, 100 MHz
	input  wire logic                     arst_n,     // Asynchronous reset, active low
	input  wire logic                     hostWr,     // Host write strobe, one clock
	input  wire logic                     hostRd,     // Host read strobe, one clock
	input  wire logic                     hostA0,     // High: command, low: data
	input  wire logic [7:0]               hostDin,    // Host write data
	output logic [7:0]                    hostDout,   // Host read data
	output logic                          hostBusy,   // Access in flight, host waits
	input  wire lcd_scan_pkg::scan_cfg_t  scanCfg,    // Scan geometry
	input  wire lcd_scan_pkg::cursor_cfg_t cursorCfg, // Cursor layer and shape setup
	input  wire logic [7:0]               memRdata,   // Memory data, two clocks after grant
	output lcd_scan_pkg::mem_req_t        memReq,     // Memory request
	output logic [7:0]                    dispData,   // Fetched scan byte
	output lcd_scan_pkg::scan_out_t       scanOut,    // Scan address and timing
	output logic [15:0]                   cursorAddr, // Cursor address register
	output logic                          cursorVisible, // Cursor drawn
	output logic                          cursorBlock // Block shape, else bar
);
	import lcd_scan_pkg::*;

	host_state_t state_q;
	host_state_t state_d;
	logic [15:0] cursor_q;
	logic [15:0] cursor_d;
	logic [1:0]  dir_q;
	logic [1:0]  dir_d;
	logic [7:0]  setLo_q;
	logic [7:0]  setLo_d;
	logic        wrPend_q;
	logic        wrPend_d;
	logic [7:0]  wrData_q;
	logic [7:0]  wrData_d;
	logic        rdPend_q;
	logic        rdPend_d;
	logic [1:0]  hostCap_q;
	logic [1:0]  scanCap_q;
	logic        busy_q;
	logic [7:0]  hostDout_q;
	logic [7:0]  hostDout_d;
	mem_req_t    memReq_q;
	mem_req_t    memReq_d;
	logic [7:0]  dispData_q;

	logic [15:0] scanAddr_q;
	logic [15:0] scanAddr_d;
	logic [15:0] upStart_q;
	logic [15:0] upStart_d;
	logic [15:0] loStart_q;
	logic [15:0] loStart_d;
	logic [3:0]  cgRow_q;
	logic [3:0]  cgRow_d;
	logic [7:0]  lineCnt_q;
	logic [7:0]  lineCnt_d;
	logic        lower_q;
	logic        lower_d;
	scan_out_t   scanOut_q;
	scan_out_t   scanOut_d;

	logic [31:0] hideCnt_q;
	logic        hidden_q;
	logic        visible_q;
	logic        block_q;

	wire fetchSlot;
	wire lineEnd;

	read_slot_timer u_timer (
		.clk            (clk),
		.arst_n         (arst_n),
		.charsPerRow    (scanCfg.charsPerRow),
		.totalRowLength (scanCfg.totalRowLength),
		.fetchSlot      (fetchSlot),
		.lineEnd        (lineEnd)
	);

	// Host decode; everything is refused while an access is in flight
	wire accepted  = ~busy_q;
	wire isCmd     = hostWr & hostA0 & accepted;
	wire isDataWr  = hostWr & ~hostA0 & accepted;
	wire isDataRd  = hostRd & ~hostA0 & accepted;
	wire isDirCmd  = hostDin[7:2] == CMD_DIR_PREFIX;

	// Scan fetch slots have priority; host uses the other eight clocks of each read cycle and the line pause
	wire hostSlot  = ~fetchSlot;
	wire grantWr   = wrPend_q & hostSlot;
	wire grantRd   = rdPend_q & hostSlot & ~wrPend_q;

	wire [15:0] stepped   = stepAddr(cursor_q, dir_q, scanCfg.addressPitch);
	wire [15:0] stepTwice = stepAddr(stepped, dir_q, scanCfg.addressPitch);
	wire [15:0] readAddr  = cursorCfg.cursorOn ? stepTwice : cursor_q;

	wire busy_d = wrPend_d | rdPend_d | hostCap_q[0] | grantRd;

	// Host command and data sequencing
	always_comb begin
		state_d  = state_q;
		cursor_d = cursor_q;
		dir_d    = dir_q;
		setLo_d  = setLo_q;
		wrPend_d = wrPend_q;
		wrData_d = wrData_q;
		rdPend_d = rdPend_q;
		if (isCmd) begin
			if (isDirCmd) begin
				dir_d   = hostDin[DIR_LSB +: 2];
				state_d = ST_IDLE;
			end else if (hostDin == CMD_SET_CURSOR) begin
				state_d = ST_SETLO;
			end else if (hostDin == CMD_READ_CURSOR) begin
				state_d = ST_CSRLO;
			end else if (hostDin == CMD_MEM_WRITE) begin
				state_d = ST_WRDATA;
			end else if (hostDin == CMD_MEM_READ) begin
				state_d  = ST_RDDATA;
				rdPend_d = 1'b1;
			end else begin
				state_d = ST_IDLE;
			end
		end else if (isDataWr) begin
			case (state_q)
				ST_SETLO: begin
					setLo_d = hostDin;
					state_d = ST_SETHI;
				end
				ST_SETHI: begin
					cursor_d = {hostDin, setLo_q};
					state_d  = ST_IDLE;
				end
				ST_WRDATA: begin
					wrPend_d = 1'b1;
					wrData_d = hostDin;
				end
				default: state_d = state_q;
			endcase
		end else if (isDataRd) begin
			case (state_q)
				ST_RDDATA: begin
					cursor_d = stepped;
					rdPend_d = 1'b1;
				end
				ST_CSRLO: state_d = ST_CSRHI;
				ST_CSRHI: state_d = ST_IDLE;
				default:  state_d = state_q;
			endcase
		end
		if (grantWr) begin
			wrPend_d = 1'b0;
			cursor_d = stepped;
		end
		if (grantRd) begin
			rdPend_d = 1'b0;
		end
	end

	// Read data: captured host read byte first, cursor bytes in readback states, else held
	always_comb begin
		hostDout_d = hostDout_q;
		if (hostCap_q[1]) begin
			hostDout_d = memRdata;
		end else if (state_d == ST_CSRLO) begin
			hostDout_d = cursor_q[7:0];
		end else if (state_d == ST_CSRHI) begin
			hostDout_d = cursor_q[15:8];
		end
	end

	// Only this block drives the memory port; the host has no path of its own
	always_comb begin
		memReq_d = '0;
		if (fetchSlot) begin
			memReq_d.re   = 1'b1;
			memReq_d.addr = scanAddr_q;
		end else if (grantWr) begin
			memReq_d.we    = 1'b1;
			memReq_d.addr  = cursor_q;
			memReq_d.wdata = wrData_q;
		end else if (grantRd) begin
			memReq_d.re   = 1'b1;
			memReq_d.addr = readAddr;
		end
	end

	// Line and panel stepping
	wire        lastPanel = ~scanCfg.dualPanel | lower_q;
	wire        rowDone   = scanCfg.graphicsMode | (cgRow_q == scanCfg.charFieldHeight);
	wire        frameDone = lineCnt_q == scanCfg.panelLines;
	wire [15:0] upNext    = upStart_q + scanCfg.addressPitch;
	wire [15:0] loNext    = loStart_q + scanCfg.addressPitch;
	wire [1:0]  rowBytes  = (scanCfg.charFieldWidth >= WIDE_FIELD_MIN) ? 2'h2 : 2'h1;

	always_comb begin
		upStart_d = upStart_q;
		loStart_d = loStart_q;
		cgRow_d   = cgRow_q;
		lineCnt_d = lineCnt_q;
		lower_d   = lower_q;
		if (lineEnd) begin
			lower_d = scanCfg.dualPanel & ~lower_q;
			if (lastPanel) begin
				if (frameDone) begin
					upStart_d = scanCfg.upperStart;
					loStart_d = scanCfg.lowerStart;
					cgRow_d   = 4'h0;
					lineCnt_d = 8'h00;
				end else begin
					lineCnt_d = lineCnt_q + 8'h01;
					cgRow_d   = rowDone ? 4'h0 : cgRow_q + 4'h1;
					if (rowDone) begin
						upStart_d = upNext;
						loStart_d = loNext;
					end
				end
			end
		end
	end

	always_comb begin
		scanAddr_d = scanAddr_q;
		if (lineEnd) begin
			scanAddr_d = lower_d ? loStart_d : upStart_d;
		end else if (fetchSlot) begin
			scanAddr_d = scanAddr_q + 16'h0001;
		end
	end

	always_comb begin
		scanOut_d            = '0;
		scanOut_d.fetch      = fetchSlot;
		scanOut_d.addr       = scanAddr_q;
		scanOut_d.cgRow      = cgRow_q;
		scanOut_d.rowBytes   = rowBytes;
		scanOut_d.lowerPanel = lower_q;
		scanOut_d.linePulse  = lineEnd & lastPanel;
	end

	// Cursor layer and shape
	wire [15:0] layerBase = cursorCfg.threeLayer ? cursorCfg.layer3Base : cursorCfg.layer1Base;
	wire [15:0] layerSize = cursorCfg.threeLayer ? cursorCfg.layer3Size : cursorCfg.layer1Size;
	wire        inLayer   = inWindow(cursor_q, layerBase, layerSize);
	wire        onText    = inWindow(cursor_q, cursorCfg.textBase, cursorCfg.textSize);
	wire        hideHit   = hideCnt_q == 32'(HIDE_CLKS);
	wire        visible_d = cursorCfg.cursorOn & inLayer & ~hidden_q;
	wire        blockText = ~cursorCfg.mixedFirst | onText;
	wire        block_d   = cursorCfg.textShown & cursorCfg.blockShape & blockText;

	// Off-screen timer; visible_d also needs inLayer, so even brief excursions hide the cursor
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hideCnt_q <= 32'h0000_0000;
			hidden_q  <= 1'b0;
		end else if (inLayer) begin
			hideCnt_q <= 32'h0000_0000;
			hidden_q  <= 1'b0;
		end else if (hideHit) begin
			hidden_q  <= 1'b1;
		end else begin
			hideCnt_q <= hideCnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q  <= ST_IDLE;
			cursor_q <= CURSOR_RESET;
			dir_q    <= DIR_RESET;
			setLo_q  <= 8'h00;
		end else begin
			state_q  <= state_d;
			cursor_q <= cursor_d;
			dir_q    <= dir_d;
			setLo_q  <= setLo_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPend_q  <= 1'b0;
			wrData_q  <= 8'h00;
			rdPend_q  <= 1'b0;
			busy_q    <= 1'b0;
			hostCap_q <= 2'h0;
			hostDout_q <= 8'h00;
		end else begin
			wrPend_q  <= wrPend_d;
			wrData_q  <= wrData_d;
			rdPend_q  <= rdPend_d;
			busy_q    <= busy_d;
			hostCap_q <= {hostCap_q[0], grantRd};
			hostDout_q <= hostDout_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			memReq_q   <= '0;
			scanCap_q  <= 2'h0;
			dispData_q <= 8'h00;
		end else begin
			memReq_q   <= memReq_d;
			scanCap_q  <= {scanCap_q[0], fetchSlot};
			if (scanCap_q[1]) begin
				dispData_q <= memRdata;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scanAddr_q <= 16'h0000;
			upStart_q  <= 16'h0000;
			loStart_q  <= 16'h0000;
			cgRow_q    <= 4'h0;
			lineCnt_q  <= 8'h00;
			lower_q    <= 1'b0;
			scanOut_q  <= '0;
		end else begin
			scanAddr_q <= scanAddr_d;
			upStart_q  <= upStart_d;
			loStart_q  <= loStart_d;
			cgRow_q    <= cgRow_d;
			lineCnt_q  <= lineCnt_d;
			lower_q    <= lower_d;
			scanOut_q  <= scanOut_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			visible_q <= 1'b0;
			block_q   <= 1'b0;
		end else begin
			visible_q <= visible_d;
			block_q   <= block_d;
		end
	end

	assign hostDout      = hostDout_q;
	assign hostBusy      = busy_q;
	assign memReq        = memReq_q;
	assign dispData      = dispData_q;
	assign scanOut       = scanOut_q;
	assign cursorAddr    = cursor_q;
	assign cursorVisible = visible_q;
	assign cursorBlock   = block_q;
endmodule

// ==== hdl/lcd_scan_pkg.sv ====
// Shared constants, types and helpers of the cursor access and scan block
package lcd_scan_pkg;
	localparam int CLK_KHZ          = 100000;
	localparam int READ_CYCLE_CLKS  = 9;
	localparam int CURSOR_HIDE_MS   = 300;
	localparam int CURSOR_HIDE_CLKS = CURSOR_HIDE_MS * CLK_KHZ;

	localparam logic [7:0]  CMD_SET_CURSOR  = 8'h46;
	localparam logic [7:0]  CMD_READ_CURSOR = 8'h47;
	localparam logic [7:0]  CMD_MEM_WRITE   = 8'h42;
	localparam logic [7:0]  CMD_MEM_READ    = 8'h43;
	localparam logic [5:0]  CMD_DIR_PREFIX  = 6'h13;
	localparam int          DIR_LSB         = 0;

	localparam logic [1:0]  DIR_RIGHT       = 2'h0;
	localparam logic [1:0]  DIR_LEFT        = 2'h1;
	localparam logic [1:0]  DIR_UP          = 2'h2;
	localparam logic [1:0]  DIR_DOWN        = 2'h3;

	localparam logic [15:0] CURSOR_RESET    = 16'h0000;
	localparam logic [1:0]  DIR_RESET       = DIR_RIGHT;
	localparam logic [3:0]  WIDE_FIELD_MIN  = 4'h8;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETLO  = 3'b001,
		ST_SETHI  = 3'b011,
		ST_WRDATA = 3'b010,
		ST_RDDATA = 3'b110,
		ST_CSRLO  = 3'b111,
		ST_CSRHI  = 3'b101
	} host_state_t;

	typedef struct packed {
		logic [7:0]  charsPerRow;
		logic [7:0]  totalRowLength;
		logic [15:0] addressPitch;
		logic [3:0]  charFieldWidth;
		logic [3:0]  charFieldHeight;
		logic        graphicsMode;
		logic        dualPanel;
		logic [7:0]  panelLines;
		logic [15:0] upperStart;
		logic [15:0] lowerStart;
	} scan_cfg_t;

	typedef struct packed {
		logic        cursorOn;
		logic        threeLayer;
		logic        textShown;
		logic        mixedFirst;
		logic        blockShape;
		logic [15:0] layer1Base;
		logic [15:0] layer1Size;
		logic [15:0] layer3Base;
		logic [15:0] layer3Size;
		logic [15:0] textBase;
		logic [15:0] textSize;
	} cursor_cfg_t;

	typedef struct packed {
		logic        re;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} mem_req_t;

	typedef struct packed {
		logic        fetch;
		logic [15:0] addr;
		logic [3:0]  cgRow;
		logic [1:0]  rowBytes;
		logic        lowerPanel;
		logic        linePulse;
	} scan_out_t;

	// Sixteen-bit arithmetic wraps by itself at both ends
	function automatic logic [15:0] stepAddr(input logic [15:0] a, input logic [1:0] dir,
		input logic [15:0] pitch);
		logic [15:0] r;
		r = a;
		case (dir)
			DIR_RIGHT: r = a + 16'h0001;
			DIR_LEFT:  r = a - 16'h0001;
			DIR_UP:    r = a - pitch;
			default:   r = a + pitch;
		endcase
		return r;
	endfunction

	function automatic logic inWindow(input logic [15:0] a, input logic [15:0] base,
		input logic [15:0] size);
		logic [15:0] off;
		off = a - base;
		return off < size;
	endfunction
endpackage

// ==== hdl/read_slot_timer.sv ====
// Nine-clock read cycle timer with per-line fetch and pause phases
`timescale 1ns/1ps
module read_slot_timer (
	input  wire logic       clk,            // System clock
	input  wire logic       arst_n,         // Asynchronous reset, active low
	input  wire logic [7:0] charsPerRow,    // Last fetched address count of a line
	input  wire logic [7:0] totalRowLength, // Last read cycle count of a line
	output logic            fetchSlot,      // Scan owns memory this clock
	output logic            lineEnd         // Last clock of the line
);
	import lcd_scan_pkg::*;

	localparam logic [3:0] LAST_PHASE = 4'(READ_CYCLE_CLKS - 1);

	logic [3:0] phase_q;
	logic [7:0] cycle_q;

	wire phaseEnd  = phase_q == LAST_PHASE;
	wire rowEnd    = cycle_q == totalRowLength;
	wire inFetch   = cycle_q <= charsPerRow;

	assign fetchSlot = (phase_q == 4'h0) && inFetch;
	assign lineEnd   = phaseEnd && rowEnd;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= 4'h0;
			cycle_q <= 8'h00;
		end else begin
			phase_q <= phaseEnd ? 4'h0 : phase_q + 4'h1;
			if (phaseEnd) begin
				cycle_q <= rowEnd ? 8'h00 : cycle_q + 8'h01;
			end
		end
	end
endmodule

// ==== bench/lcd_cursor_scan_props.sv ====
// Port checker of the cursor access and scan block
`timescale 1ns/1ps
module lcd_cursor_scan_props (
	input wire logic                      clk,           // System clock
	input wire logic                      arst_n,        // Reset, active low
	input wire logic                      hostWr,        // Host write strobe
	input wire logic                      hostRd,        // Host read strobe
	input wire logic                      hostBusy,      // Host access pending
	input wire lcd_scan_pkg::scan_cfg_t   scanCfg,       // Scan geometry
	input wire lcd_scan_pkg::cursor_cfg_t cursorCfg,     // Cursor setup
	input wire lcd_scan_pkg::mem_req_t    memReq,        // Memory request
	input wire lcd_scan_pkg::scan_out_t   scanOut,       // Scan timing
	input wire logic [15:0]               cursorAddr,    // Cursor address
	input wire logic                      cursorVisible, // Cursor drawn
	input wire logic                      cursorBlock    // Block shape
);
	import lcd_scan_pkg::*;
	logic [2:0]  sinceStb_q;
	logic [11:0] lineClk_q;
	logic [8:0]  lineFet_q;
	logic        seen_q;
	wire  [11:0] lineMul = scanCfg.dualPanel ? 12'h002 : 12'h001;
	wire  [11:0] linePer = ({4'h0, scanCfg.totalRowLength} + 12'h001) * 12'h009 * lineMul;
	wire  [8:0]  fetExp = ({1'h0, scanCfg.charsPerRow} + 9'h001) * lineMul[8:0];

	// Counting starts at reset, not at a pulse, so only lines after the first pulse are measured
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sinceStb_q <= 3'h7;
			lineClk_q  <= 12'h000;
			lineFet_q  <= 9'h000;
			seen_q     <= 1'b0;
		end else begin
			sinceStb_q <= (hostWr || hostRd) ? 3'h0 : sinceStb_q + {2'h0, sinceStb_q != 3'h7};
			lineClk_q  <= scanOut.linePulse ? 12'h000 : lineClk_q + 12'h001;
			lineFet_q  <= (scanOut.linePulse ? 9'h000 : lineFet_q) + {8'h00, scanOut.fetch};
			seen_q     <= seen_q || scanOut.linePulse;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence fetchGap_s;
		!scanOut.fetch [*8];
	endsequence
	sequence busyEnds_s;
		##[1:6] !hostBusy;
	endsequence

	fetch_gap_a: assert property (scanOut.fetch |=> fetchGap_s)
		else $error("fetch pulses closer than one read cycle");
	line_period_a: assert property (seen_q && scanOut.linePulse |-> lineClk_q == linePer - 12'h001)
		else $error("line length differs from total row length");
	fetch_count_a: assert property (seen_q && scanOut.linePulse |-> lineFet_q == fetExp)
		else $error("wrong fetch count per line");
	lower_pulse_a: assert property (scanCfg.dualPanel && scanOut.linePulse |-> $past(scanOut.lowerPanel))
		else $error("latch pulse after upper panel line");
	single_panel_a: assert property (!scanCfg.dualPanel |-> !scanOut.lowerPanel)
		else $error("lower panel flagged in single panel mode");
	busy_bound_a: assert property ($rose(hostBusy) |-> busyEnds_s)
		else $error("host access not finished in time");
	cursor_cause_a: assert property ($changed(cursorAddr) |-> sinceStb_q <= 3'h4)
		else $error("cursor moved without host access");
	write_addr_a: assert property (memReq.we |-> memReq.addr == $past(cursorAddr))
		else $error("write not at cursor address");
	bar_only_a: assert property (cursorVisible && !cursorCfg.textShown && $stable(cursorCfg) |-> !cursorBlock)
		else $error("block cursor without text screen");
	row_bytes_a: assert property (scanOut.fetch |-> scanOut.rowBytes ==
		((scanCfg.charFieldWidth >= WIDE_FIELD_MIN) ? 2'h2 : 2'h1))
		else $error("bitmap row byte count wrong");
endmodule

// ==== bench/display_mem_model.sv ====
// Display memory behind the block, answers one clock after a read request
`timescale 1ns/1ps
module display_mem_model (
	input  wire logic                   clk,     // System clock
	input  wire lcd_scan_pkg::mem_req_t memReq,  // Request from the block
	output logic [7:0]                  memRdata // Read data, valid one cycle
);
	logic [7:0] mem [logic [15:0]];
	logic [7:0] lastQ = 8'h00;
	logic       validQ = 1'b0;

	// Only the block's request port reaches the array
	always @(posedge clk) begin
		if (memReq.we)
			mem[memReq.addr] = memReq.wdata;
		validQ <= memReq.re;
		if (memReq.re)
			lastQ <= mem.exists(memReq.addr) ? mem[memReq.addr] : memReq.addr[7:0] ^ 8'h5a;
	end
	// Outside the valid cycle the bus shows garbage, not the last value
	assign memRdata = validQ ? lastQ : ~lastQ;
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the cursor access and scan block
`timescale 1ns/1ps
module tb;
	import lcd_scan_pkg::*;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        hostWr = 1'b0;
	logic        hostRd = 1'b0;
	logic        hostA0 = 1'b0;
	logic [7:0]  hostDin = 8'h00;
	logic [7:0]  hostDout;
	logic        hostBusy;
	scan_cfg_t   scanCfg;
	cursor_cfg_t cursorCfg;
	logic [7:0]  memRdata;
	mem_req_t    memReq;
	logic [7:0]  dispData;
	scan_out_t   scanOut;
	logic [15:0] cursorAddr;
	logic        cursorVisible;
	logic        cursorBlock;
	logic [15:0] bases [4] = '{16'hffff, 16'h0000, 16'h0010, 16'hfff0};
	logic [15:0] steps [4] = '{16'h0000, 16'hffff, 16'hffe8, 16'h0018};
	logic [7:0]  pat [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
	int          num_errors = 0;
	int          checks_done = 0;
	int          cycles = 0;

	always #5 clk = ~clk;

	lcd_cursor_scan #(.HIDE_CLKS(50)) u_lcd_cursor_scan (.clk, .arst_n, .hostWr, .hostRd, .hostA0,
		.hostDin, .hostDout, .hostBusy, .scanCfg, .cursorCfg, .memRdata, .memReq, .dispData, .scanOut,
		.cursorAddr, .cursorVisible, .cursorBlock);
	display_mem_model u_display_mem_model (.clk, .memReq, .memRdata);

	task automatic end_sim();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			$display("[ERR] %0t run did not finish", $time);
			end_sim();
		end
	end

	// Callers lower reset themselves, so config changes land while it is held
	task automatic doReset();
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
	endtask

	// Busy rises on the clock edge that takes the strobe; polling starts two clocks after the strobe ends
	task automatic waitIdle();
		int n;
		n = 0;
		repeat (2) @(negedge clk);
		while (hostBusy !== 1'b0 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n == 40)
			check(16'h0001, 16'h0000);
	endtask

	task automatic hostWrite(input logic a0, input logic [7:0] d);
		@(negedge clk);
		hostWr = 1'b1;
		hostA0 = a0;
		hostDin = d;
		@(negedge clk);
		hostWr = 1'b0;
		waitIdle();
	endtask

	task automatic hostRead(output logic [7:0] d);
		@(negedge clk);
		hostRd = 1'b1;
		hostA0 = 1'b0;
		d = hostDout;
		@(negedge clk);
		hostRd = 1'b0;
		waitIdle();
	endtask

	task automatic setCursor(input logic [15:0] a);
		hostWrite(1'b1, CMD_SET_CURSOR);
		hostWrite(1'b0, a[7:0]);
		hostWrite(1'b0, a[15:8]);
	endtask

	// Line starts must follow the pitch, and each line runs up by one
	task automatic watchScan(input int nLines);
		logic [15:0] start;
		logic [15:0] prev;
		logic [3:0]  row;
		logic        first;
		int          line;
		start = 16'h0000;
		prev = 16'h0000;
		row = 4'h0;
		first = 1'b0;
		line = -1;
		while (line < nLines) begin
			@(negedge clk);
			if (scanOut.linePulse === 1'b1) begin
				line++;
				first = 1'b1;
			end
			if (scanOut.fetch === 1'b1 && line >= 0) begin
				if (first && line > 0) begin
					row = (row == scanCfg.charFieldHeight) ? 4'h0 : row + 4'h1;
					if (scanCfg.graphicsMode || row == 4'h0)
						start = start + scanCfg.addressPitch;
					check(scanOut.addr, start);
					if (!scanCfg.graphicsMode)
						check({12'h000, scanOut.cgRow}, {12'h000, row});
				end else if (first) begin
					start = scanOut.addr;
					row = scanOut.cgRow;
				end else
					check(scanOut.addr, prev + 16'h0001);
				prev = scanOut.addr;
				first = 1'b0;
			end
		end
	endtask

	initial begin
		logic [7:0] b;
		logic [7:0] csrHi;
		logic       sawLow;
		logic       sawHigh;
		scanCfg = '{charsPerRow: 8'h03, totalRowLength: 8'h05, addressPitch: 16'h0028,
			charFieldWidth: 4'h7, charFieldHeight: 4'h1, graphicsMode: 1'b1, dualPanel: 1'b0,
			panelLines: 8'hff, upperStart: 16'h0000, lowerStart: 16'h0400};
		cursorCfg = '{textShown: 1'b1, blockShape: 1'b1, layer1Size: 16'h1000, layer3Base: 16'h2000,
			layer3Size: 16'h1000, default: '0};
		doReset();
		check(cursorAddr, CURSOR_RESET);
		setCursor(16'hbeef);
		check(cursorAddr, 16'hbeef);
		hostWrite(1'b1, CMD_READ_CURSOR);
		hostRead(b);
		check({8'h00, b}, 16'h00ef);
		hostRead(b);
		check({8'h00, b}, 16'h00be);
		hostWrite(1'b0, 8'h12);
		check(cursorAddr, 16'hbeef);
		for (int d = 0; d < 4; d++) begin
			hostWrite(1'b1, {CMD_DIR_PREFIX, 2'(d)});
			setCursor(bases[d]);
			hostWrite(1'b1, CMD_MEM_WRITE);
			hostWrite(1'b0, 8'ha0 + 8'(d));
			check(cursorAddr, steps[d]);
		end
		hostWrite(1'b1, {CMD_DIR_PREFIX, DIR_RIGHT});
		setCursor(16'h0100);
		foreach (pat[i]) begin
			if (i % 2 == 0)
				hostWrite(1'b1, CMD_MEM_WRITE);
			hostWrite(1'b0, pat[i]);
		end
		check(cursorAddr, 16'h0104);
		setCursor(16'hffff);
		hostWrite(1'b1, CMD_MEM_READ);
		hostRead(b);
		check({8'h00, b}, 16'h00a0);
		hostRead(b);
		check({8'h00, b}, 16'h00a1);
		check(cursorAddr, 16'h0001);
		setCursor(16'h0100);
		hostWrite(1'b1, CMD_MEM_READ);
		foreach (pat[i]) begin
			hostRead(b);
			check({8'h00, b}, {8'h00, pat[i]});
		end
		cursorCfg.cursorOn = 1'b1;
		setCursor(16'h0100);
		hostWrite(1'b1, CMD_MEM_READ);
		hostRead(b);
		check({8'h00, b}, 16'h0033);
		hostRead(b);
		check({8'h00, b}, 16'h0044);
		check(cursorAddr, 16'h0102);
		hostWrite(1'b1, 8'h00);
		hostRead(b);
		check(cursorAddr, 16'h0102);
		repeat (3) @(negedge clk);
		check({14'h0000, cursorVisible, cursorBlock}, 16'h0003);
		cursorCfg.textShown = 1'b0;
		repeat (3) @(negedge clk);
		check({15'h0000, cursorBlock}, 16'h0000);
		cursorCfg.threeLayer = 1'b1;
		repeat (3) @(negedge clk);
		check({15'h0000, cursorVisible}, 16'h0000);
		repeat (60) @(negedge clk);
		cursorCfg.threeLayer = 1'b0;
		cursorCfg.textShown = 1'b1;
		cursorCfg.mixedFirst = 1'b1;
		cursorCfg.textSize = 16'h0080;
		repeat (3) @(negedge clk);
		check({14'h0000, cursorVisible, cursorBlock}, 16'h0002);
		cursorCfg.textSize = 16'h0200;
		repeat (3) @(negedge clk);
		check({15'h0000, cursorBlock}, 16'h0001);
		// Host saves the cursor around an off-screen write and puts it back
		hostWrite(1'b1, CMD_READ_CURSOR);
		hostRead(b);
		hostRead(csrHi);
		setCursor(16'h8000);
		hostWrite(1'b1, CMD_MEM_WRITE);
		hostWrite(1'b0, 8'h5c);
		setCursor({csrHi, b});
		check(cursorAddr, 16'h0102);
		watchScan(6);
		check({14'h0000, scanOut.rowBytes}, 16'h0001);
		arst_n = 1'b0;
		scanCfg.graphicsMode = 1'b0;
		scanCfg.charFieldWidth = 4'h9;
		doReset();
		watchScan(6);
		check({14'h0000, scanOut.rowBytes}, 16'h0002);
		arst_n = 1'b0;
		scanCfg.dualPanel = 1'b1;
		doReset();
		sawLow = 1'b0;
		sawHigh = 1'b0;
		repeat (400) begin
			@(negedge clk);
			sawLow = sawLow | (scanOut.lowerPanel === 1'b0);
			sawHigh = sawHigh | (scanOut.lowerPanel === 1'b1);
		end
		check({15'h0000, sawLow & sawHigh}, 16'h0001);
		end_sim();
	end
endmodule

bind lcd_cursor_scan lcd_cursor_scan_props u_lcd_cursor_scan_props (.clk, .arst_n, .hostWr, .hostRd,
	.hostBusy, .scanCfg, .cursorCfg, .memReq, .scanOut, .cursorAddr, .cursorVisible, .cursorBlock);
